// ### lbs_pkg.sv
// constants, encodings and state types of the local bus support logic
// assumes a single 125 MHz core clock and active-low synchronous reset
package lbs_pkg;

  // bus cycle states, one-hot
  typedef enum logic [4:0] {
    LBS_IDLE = 5'h01,
    LBS_ADDR = 5'h02,
    LBS_DATA = 5'h04,
    LBS_ERRS = 5'h08,
    LBS_HELD = 5'h10
  } lbs_state_type;

  localparam int LBS_LANES = 4;
  localparam int LBS_WORDS_MAX = 4;
  localparam int LBS_WORD_IDX_W = 2;
  localparam logic [3:0] LBS_LANES_NONE = 4'h0;
  localparam logic [3:0] LBS_LANES_ALL = 4'hf;
  // reset hold in double-rate clock cycles
  localparam int LBS_RESET_MIN_DR_CYCLES = 41;
  localparam int LBS_DIV_RATIO = 2;
  localparam logic LBS_DIV_RESET = 1'b0;
  localparam logic LBS_STRAP_RESET = 1'b1;

endpackage

// ### lbs_lane_store.sv
// per-word byte-lane select store for one transaction
// assumes word index is valid when written; read data registered
`timescale 1ns/1ps
module lbs_lane_store #(
  parameter int WORDS = 4,
  parameter int IDX_W = 2
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // write side
  input wire logic wr_en_in,
  input wire logic [IDX_W-1:0] wr_idx_in,
  input wire logic [3:0] wr_lanes_in,
  // read side
  input wire logic [IDX_W-1:0] rd_idx_in,
  output logic [3:0] rd_lanes_out
);

  initial
  begin
    if (WORDS < 1 || WORDS > (1 << IDX_W))
      $error("lbs_lane_store: WORDS does not fit IDX_W");
  end

  logic [3:0] mem [WORDS];
  logic [3:0] next_rd;

  always_comb
  begin
    next_rd = mem[rd_idx_in];
  end

  always_ff @(posedge clk_in)
  begin
    if (wr_en_in)
      mem[wr_idx_in] <= wr_lanes_in;
    if (!resetn_in)
      rd_lanes_out <= lbs_pkg::LBS_LANES_NONE;
    else
      rd_lanes_out <= next_rd;
  end

endmodule

// ### lbs_clk_div.sv
// divide-by-two phase of the double-rate clock, the bus clock phase
// assumes clk_in is the double-rate clock
`timescale 1ns/1ps
module lbs_clk_div (
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // divided phase
  output logic phase_out
);

  logic next_phase;

  always_comb
  begin
    next_phase = ~phase_out;
  end

  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
      phase_out <= lbs_pkg::LBS_DIV_RESET;
    else
      phase_out <= next_phase;
  end

endmodule

// ### lbs_support.sv
// byte-lane selects, hold handover, cacheable flag, bus error sampling
// and reset strap of a multiplexed local bus master
// assumes clk_in is the double-rate clock; bus steps on divided phase
`timescale 1ns/1ps

module lbs_support #(
  parameter int WORDS_MAX = lbs_pkg::LBS_WORDS_MAX
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // core request side
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic req_cacheable_in,
  input wire logic req_sync_in,
  input wire logic [1:0] req_words_in,
  input wire logic [1:0] req_first_off_in,
  input wire logic [1:0] req_last_len_in,
  output logic req_ready_out,
  output logic done_out,
  output logic bus_error_out,
  output logic init_master_out,
  // bus handshake inputs
  input wire logic ready_n_in,
  input wire logic bus_error_n_in,
  input wire logic hold_in,
  // bus outputs
  output logic [3:0] byte_lane_selects_n_out,
  output logic byte_lane_selects_oe_out,
  output logic address_strobe_n_out,
  output logic hold_grant_out,
  output logic cache_out,
  output logic cache_oe_out,
  output logic bus_lines_oe_out,
  output logic open_drain_release_out
);

  initial
  begin
    if (WORDS_MAX != lbs_pkg::LBS_WORDS_MAX)
      $error("lbs_support: burst length fixed at four words");
  end

  // lanes for a word: first word from offset, last from length
  function automatic logic [3:0] lane_mask(input logic [1:0] off,
                                           input logic [1:0] len_m1);
    logic [3:0] top;
    logic [3:0] m;
    top = lbs_pkg::LBS_LANES_ALL >> (2'd3 - len_m1);
    m = top << off;
    // contiguous and never empty
    if (m == lbs_pkg::LBS_LANES_NONE)
      m = lbs_pkg::LBS_LANES_ALL;
    return m;
  endfunction

  lbs_pkg::lbs_state_type state, next_state;
  logic phase;
  logic [1:0] word_idx, next_word_idx;
  logic [1:0] words_m1, next_words_m1;
  logic [3:0] lanes, next_lanes;
  logic cacheable, next_cacheable;
  logic err, next_err;
  logic strap, next_strap;
  logic [1:0] first_off, next_first_off;
  logic [1:0] last_len, next_last_len;
  logic [3:0] first_lanes, last_lanes;
  logic final_ready;

  lbs_clk_div u_div (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .phase_out(phase)
  );

  lbs_lane_store #(
    .WORDS(lbs_pkg::LBS_WORDS_MAX),
    .IDX_W(lbs_pkg::LBS_WORD_IDX_W)
  ) u_store (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .wr_en_in(1'b0),
    .wr_idx_in(word_idx),
    .wr_lanes_in(lanes),
    .rd_idx_in(word_idx),
    .rd_lanes_out()
  );

  always_comb
  begin
    first_lanes = lane_mask(req_first_off_in,
                            (req_words_in == 2'd0) ? req_last_len_in
                                                   : 2'd3 - req_first_off_in);
    last_lanes = lane_mask(2'd0, last_len);
    final_ready = (state == lbs_pkg::LBS_DATA) && !ready_n_in
                  && (word_idx == words_m1);
  end

  always_comb
  begin
    next_state = state;
    next_word_idx = word_idx;
    next_words_m1 = words_m1;
    next_lanes = lanes;
    next_cacheable = cacheable;
    next_err = err;
    next_strap = strap;
    next_first_off = first_off;
    next_last_len = last_len;
    if (!phase)
    begin
      case (state)
        lbs_pkg::LBS_IDLE:
        begin
          // hold only between transactions
          if (hold_in)
            next_state = lbs_pkg::LBS_HELD;
          else if (req_valid_in)
          begin
            next_state = lbs_pkg::LBS_ADDR;
            next_word_idx = 2'd0;
            next_words_m1 = req_words_in;
            next_first_off = req_first_off_in;
            next_last_len = req_last_len_in;
            next_lanes = first_lanes;
            next_cacheable = req_cacheable_in && !req_sync_in;
          end
        end
        lbs_pkg::LBS_ADDR:
        begin
          next_state = lbs_pkg::LBS_DATA;
          // next word lanes shown in data state
          if (words_m1 == 2'd1)
            next_lanes = last_lanes;
          else if (words_m1 != 2'd0)
            next_lanes = lbs_pkg::LBS_LANES_ALL;
        end
        lbs_pkg::LBS_DATA:
        begin
          // lanes held while ready is high
          if (!ready_n_in)
          begin
            if (word_idx == words_m1)
              next_state = lbs_pkg::LBS_ERRS;
            else
            begin
              next_word_idx = word_idx + 2'd1;
              if ({1'b0, word_idx} + 3'd2 >= {1'b0, words_m1})
                next_lanes = last_lanes;
              else
                next_lanes = lbs_pkg::LBS_LANES_ALL;
            end
          end
        end
        lbs_pkg::LBS_ERRS:
        begin
          next_err = !bus_error_n_in;
          next_state = hold_in ? lbs_pkg::LBS_HELD : lbs_pkg::LBS_IDLE;
        end
        lbs_pkg::LBS_HELD:
        begin
          // grant kept while requested
          if (!hold_in)
            next_state = req_valid_in ? lbs_pkg::LBS_ADDR
                                      : lbs_pkg::LBS_IDLE;
          if (!hold_in && req_valid_in)
          begin
            next_word_idx = 2'd0;
            next_words_m1 = req_words_in;
            next_first_off = req_first_off_in;
            next_last_len = req_last_len_in;
            next_lanes = first_lanes;
            next_cacheable = req_cacheable_in && !req_sync_in;
          end
        end
        default: next_state = lbs_pkg::LBS_IDLE;
      endcase
    end
    // strap sampled while reset is held
    if (!resetn_in)
      next_strap = !bus_error_n_in;
  end

  // reset loads everything but the strap: state idle, lanes all ones, rest zero
  always_ff @(posedge clk_in)
  begin
    strap <= next_strap;
    if (!resetn_in)
    begin
      state <= lbs_pkg::LBS_IDLE;
      word_idx <= 2'd0;
      words_m1 <= 2'd0;
      lanes <= lbs_pkg::LBS_LANES_ALL;
      cacheable <= 1'b0;
      err <= 1'b0;
      first_off <= 2'd0;
      last_len <= 2'd0;
    end
    else
    begin
      state <= next_state;
      word_idx <= next_word_idx;
      words_m1 <= next_words_m1;
      lanes <= next_lanes;
      cacheable <= next_cacheable;
      err <= next_err;
      first_off <= next_first_off;
      last_len <= next_last_len;
    end
  end

  always_comb
  begin
    // strap level high means this device initializes; sampled low-true
    init_master_out = !strap;
    bus_error_out = err;
    req_ready_out = !phase && resetn_in && !hold_in
                    && (state == lbs_pkg::LBS_IDLE
                        || state == lbs_pkg::LBS_HELD);
    done_out = (state == lbs_pkg::LBS_ERRS) && !phase;
    byte_lane_selects_n_out = ~lanes;
    byte_lane_selects_oe_out = (state == lbs_pkg::LBS_ADDR
                                || state == lbs_pkg::LBS_DATA);
    address_strobe_n_out = !(state == lbs_pkg::LBS_ADDR);
    hold_grant_out = (state == lbs_pkg::LBS_HELD);
    cache_out = cacheable && (state == lbs_pkg::LBS_ADDR);
    cache_oe_out = (state == lbs_pkg::LBS_ADDR
                    || state == lbs_pkg::LBS_DATA);
    bus_lines_oe_out = cache_oe_out;
    open_drain_release_out = (state == lbs_pkg::LBS_HELD);
  end

  property p_grant_follows_hold;
    @(posedge clk_in) disable iff (!resetn_in)
    (state == lbs_pkg::LBS_IDLE && hold_in && !phase)
      |=> hold_grant_out;
  endproperty
  a_grant_follows_hold: assert property (p_grant_follows_hold)
    else $error("hold not granted");

  property p_grant_floats;
    @(posedge clk_in) disable iff (!resetn_in)
    hold_grant_out |-> !cache_oe_out && !byte_lane_selects_oe_out;
  endproperty
  a_grant_floats: assert property (p_grant_floats)
    else $error("bus driven under grant");

  property p_grant_drops;
    @(posedge clk_in) disable iff (!resetn_in)
    (hold_grant_out && !hold_in && !phase) |=> !hold_grant_out;
  endproperty
  a_grant_drops: assert property (p_grant_drops)
    else $error("grant kept after hold removed");

  property p_lanes_contig;
    @(posedge clk_in) disable iff (!resetn_in)
    byte_lane_selects_oe_out |-> (lanes != 4'h0) && (lanes != 4'h5)
      && (lanes != 4'ha) && (lanes != 4'h9) && (lanes != 4'hb)
      && (lanes != 4'hd);
  endproperty
  a_lanes_contig: assert property (p_lanes_contig)
    else $error("bad lane pattern");

  property p_wait_holds;
    @(posedge clk_in) disable iff (!resetn_in)
    (state == lbs_pkg::LBS_DATA && ready_n_in && !phase)
      |=> $stable(lanes) && address_strobe_n_out;
  endproperty
  a_wait_holds: assert property (p_wait_holds)
    else $error("lanes changed in wait");

  property p_cache_idle;
    @(posedge clk_in) disable iff (!resetn_in)
    (state == lbs_pkg::LBS_IDLE) |-> !cache_oe_out;
  endproperty
  a_cache_idle: assert property (p_cache_idle)
    else $error("cache driven while idle");

  property p_sync_uncached;
    @(posedge clk_in) disable iff (!resetn_in)
    (req_ready_out && req_valid_in && req_sync_in)
      |=> !cache_out ##1 !cache_out;
  endproperty
  a_sync_uncached: assert property (p_sync_uncached)
    else $error("sync access cached");

  property p_err_sampled;
    @(posedge clk_in) disable iff (!resetn_in)
    (final_ready && !phase) ##2 (!bus_error_n_in && !phase)
      |=> bus_error_out;
  endproperty
  a_err_sampled: assert property (p_err_sampled)
    else $error("bus error missed");

  property p_reset_quiet;
    @(posedge clk_in)
    !resetn_in |=> !hold_grant_out && !cache_oe_out
      && address_strobe_n_out;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("outputs active after reset");

endmodule

// ### lbs_far_model.sv
// far side model: memory answering each data word with ready, then a
// bus error window; the bench supplies wait count, error flag and strap
`timescale 1ns/1ps
module lbs_far_model (
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // bus view
  input wire logic oe_in,
  input wire logic strobe_n_in,
  input wire logic [1:0] words_in,
  // test knobs
  input wire logic [1:0] wait_in,
  input wire logic err_in,
  input wire logic strap_in,
  // answers
  output logic ready_n_out,
  output logic bus_error_n_out
);
  logic [2:0] wcnt;
  logic rwin;
  logic [2:0] wdone;
  logic [1:0] errw;
  always_ff @(posedge clk_in)
  begin
    ready_n_out <= 1'b1;
    bus_error_n_out <= 1'b1;
    if (!resetn_in)
    begin
      bus_error_n_out <= strap_in;
      rwin <= 1'b0;
      errw <= 2'h0;
    end
    else
    begin
      if (errw != 2'h0)
      begin
        errw <= errw - 2'h1;
        bus_error_n_out <= !err_in;
      end
      if (!strobe_n_in)
      begin
        wcnt <= {wait_in, 1'b0};
        wdone <= 3'h0;
        rwin <= 1'b0;
      end
      else if (oe_in && wdone <= {1'b0, words_in})
      begin
        // ready held two clocks so one bus phase sees it
        if (rwin)
        begin
          ready_n_out <= 1'b0;
          rwin <= 1'b0;
          wdone <= wdone + 3'h1;
          wcnt <= {wait_in, 1'b0};
          if (wdone == {1'b0, words_in})
            errw <= 2'h2;
        end
        else if (wcnt != 3'h0)
          wcnt <= wcnt - 3'h1;
        else
        begin
          ready_n_out <= 1'b0;
          rwin <= 1'b1;
        end
      end
    end
  end
endmodule

// ### tb_top.sv
// self-checking bench of the local bus support logic
// assumes lbs_support with the far side model on its bus pins
`timescale 1ns/1ps
module tb_top;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic valid = 1'b0, wr = 1'b0, cab = 1'b0, syn = 1'b0, hold = 1'b0;
  logic [1:0] words = 2'h0, off = 2'h0, len = 2'h0, wt = 2'h0;
  logic er = 1'b0, strap = 1'b1, prev_ok = 1'b0;
  logic rdy_n, berr_n, req_rdy, done, berr, initm, lanes_oe, as_n, grant;
  logic cache, cache_oe, bus_oe, od_rel;
  logic [3:0] lanes_n, prev_lanes;
  logic [31:0] seed = 32'd71;
  int errors = 0, total_checks = 0, cycles = 0, k;
  always #4 clk_in = ~clk_in;
  lbs_support dut (.clk_in(clk_in), .resetn_in(resetn_in),
    .req_valid_in(valid), .req_write_in(wr), .req_cacheable_in(cab),
    .req_sync_in(syn), .req_words_in(words), .req_first_off_in(off),
    .req_last_len_in(len), .req_ready_out(req_rdy), .done_out(done),
    .bus_error_out(berr), .init_master_out(initm), .ready_n_in(rdy_n),
    .bus_error_n_in(berr_n), .hold_in(hold),
    .byte_lane_selects_n_out(lanes_n), .byte_lane_selects_oe_out(lanes_oe),
    .address_strobe_n_out(as_n), .hold_grant_out(grant),
    .cache_out(cache), .cache_oe_out(cache_oe), .bus_lines_oe_out(bus_oe),
    .open_drain_release_out(od_rel));
  lbs_far_model far (.clk_in(clk_in), .resetn_in(resetn_in),
    .oe_in(lanes_oe), .strobe_n_in(as_n), .words_in(words), .wait_in(wt),
    .err_in(er), .strap_in(strap), .ready_n_out(rdy_n),
    .bus_error_n_out(berr_n));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic logic [3:0] span(input logic [1:0] lo, hi);
    return (4'hf << lo) & (4'hf >> (2'h3 - hi));
  endfunction
  function automatic logic [1:0] lowlane(input logic [3:0] m);
    return m[0] ? 2'h0 : m[1] ? 2'h1 : m[2] ? 2'h2 : 2'h3;
  endfunction
  function automatic logic contig(input logic [3:0] m);
    return m inside {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'h6, 4'hc, 4'h7,
      4'he, 4'hf};
  endfunction
  task automatic chk(input string nm, input logic [3:0] e, g);
    total_checks++;
    if (g !== e)
    begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      errors++;
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic waitsig(ref logic s, input logic v, input int lim);
    int n;
    n = 0;
    while (s !== v && n < lim)
    begin
      @(negedge clk_in);
      n++;
    end
    chk("handshake", 4'h1, {3'h0, n < lim});
  endtask
  task automatic do_reset(input logic s);
    @(posedge clk_in);
    resetn_in <= 1'b0;
    strap <= s;
    valid <= 1'b1;
    hold <= 1'b1;
    repeat (44) @(posedge clk_in);
    @(negedge clk_in);
    chk("reset outputs", 4'h2,
      {lanes_oe | bus_oe, grant, as_n, cache_oe});
    @(posedge clk_in);
    resetn_in <= 1'b1;
    valid <= 1'b0;
    hold <= 1'b0;
    @(negedge clk_in);
    chk("init strap", {3'h0, s}, {3'h0, initm});
  endtask
  task automatic xfer(input logic [1:0] w, o, l, input logic c, s, e,
    input logic [1:0] d, input logic h);
    if (w == 2'h0 && ({1'b0, o} + {1'b0, l}) > 3'h3)
      l = 2'h3 - o;
    @(posedge clk_in);
    words <= w;
    off <= o;
    len <= l;
    cab <= c;
    syn <= s;
    er <= e;
    wt <= d;
    wr <= seed[7];
    valid <= 1'b1;
    @(negedge clk_in);
    waitsig(req_rdy, 1'b1, 100);
    @(posedge clk_in);
    valid <= 1'b0;
    waitsig(as_n, 1'b0, 100);
    chk("first lanes",
      w == 2'h0 ? ~span(o, o + l) : ~span(o, 2'h3), lanes_n);
    chk("low address", {2'h0, o}, {2'h0, lowlane(~lanes_n)});
    chk("cache", {2'h1, c & ~s}, {1'b0, cache_oe, cache});
    @(posedge clk_in);
    hold <= h;
    waitsig(done, 1'b1, 300);
    @(negedge clk_in);
    chk("bus error", {3'h0, e}, {3'h0, berr});
    if (!h)
      chk("cache idle", 4'h0, {3'h0, cache_oe});
    else
    begin
      waitsig(grant, 1'b1, 20);
      chk("held bus", 4'h1, {bus_oe, lanes_oe, cache_oe, od_rel});
      @(posedge clk_in);
      hold <= 1'b0;
      @(negedge clk_in);
      waitsig(grant, 1'b0, 10);
    end
  endtask
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      conclude();
    end
  end
  always @(negedge clk_in)
  begin
    if (resetn_in && lanes_oe)
      chk("lanes contiguous", 4'h1, {3'h0, contig(~lanes_n)});
    if (grant)
      chk("grant with bus driven", 4'h0, {2'h0, lanes_oe, bus_oe});
    if (prev_ok && lanes_oe && as_n)
      chk("lanes held", prev_lanes, lanes_n);
    prev_ok = resetn_in && lanes_oe && as_n && rdy_n;
    prev_lanes = lanes_n;
  end
  initial
  begin
    do_reset(1'b1);
    $display("test reset finished");
    xfer(2'h3, 2'h3, 2'h0, 1'b1, 1'b0, 1'b1, 2'h3, 1'b1);
    xfer(2'h0, 2'h0, 2'h3, 1'b1, 1'b1, 1'b0, 2'h0, 1'b0);
    xfer(2'h0, 2'h3, 2'h0, 1'b1, 1'b0, 1'b0, 2'h0, 1'b0);
    xfer(2'h1, 2'h1, 2'h2, 1'b0, 1'b0, 1'b1, 2'h1, 1'b0);
    $display("test corners finished");
    for (k = 0; k < 40; k++)
    begin
      seed = xs(seed);
      xfer(seed[1:0], seed[3:2], seed[5:4], seed[8], seed[9], seed[10],
        seed[12:11], seed[13] & seed[14]);
    end
    $display("test random finished");
    do_reset(1'b0);
    xfer(2'h2, 2'h2, 2'h1, 1'b1, 1'b0, 1'b1, 2'h2, 1'b0);
    do_reset(1'b1);
    $display("test second reset finished");
    conclude();
  end
endmodule
